// ### pin_readback_strap_clkout_mux.sv
// Purpose: Pin level readback, boot strap latches and indicator-1 / clock-out source selection.
// Assumes: Classic Wishbone slave, 32-bit data, registers in the low 16 bits; straps steady around reset.
// Notes: One-cycle registered ack; unmapped addresses ack with zero data and drop writes.
//
// How it works
// - Lower readback returns masked live pin levels when forced to input; bit 12 reads 0.
// - Upper readback returns receive data 1 and 2 levels in bits 1-0 likewise.
// - Boot bit 13 holds indicator-1 strap, captured at power-up only.
// - Boot bit 12 holds receive-data-3 strap, captured at power-up only.
// - Boot bit 8 holds receive-data-3 strap, recaptured at every reset.
// - Other boot fields capture their straps at power-up and at every reset.
// - Indicator-1 select: 00 daisy, 01 transmit test, 10 analog test, 11 digital clock.
// - Indicator-1 select resets to 00 when receive-data-3 strap high, else 11.
// - Clock-out select in bits 1-0 uses the same four-source encoding.
// - Clock-out select resets to 11 when receive-data-3 strap high, else 00.
// - Bit 4 of the output select register chooses the analog test clock line.
`default_nettype none
`include "pin_readback_map.svh"

module pin_readback_strap_clkout_mux #(
	parameter int ADR_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [15:0] pins_lower_i,
	input wire logic [1:0] pins_upper_i,
	input wire logic indicator1_strap_i,
	input wire logic indicator0_strap_i,
	input wire logic rxdata3_strap_i,
	input wire logic rxdata2_strap_i,
	input wire logic rxdata1_strap_i,
	input wire logic rxdata0_strap_i,
	input wire logic rxclock_strap_i,
	input wire logic [1:0] rxerror_strap_i,
	input wire logic [1:0] rxvalid_strap_i,
	input wire logic daisy_clock_i,
	input wire logic transmit_test_clock_i,
	input wire logic analog_test_clock_a_i,
	input wire logic analog_test_clock_b_i,
	input wire logic digital_clockout_i,
	output logic analog_test_line_select_o,
	output logic indicator1_o,
	output logic clockout_o
);

	// Four-way source pick shared by both output pins
	function automatic logic pick_source(
		input pin_readback_pkg::clk_src_e src,
		input logic daisy,
		input logic tx_test,
		input logic ana_test,
		input logic digital
	);
		logic r;
		case (src)
			pin_readback_pkg::SRC_DAISY_CLOCK: r = daisy;
			pin_readback_pkg::SRC_TRANSMIT_TEST_CLOCK: r = tx_test;
			pin_readback_pkg::SRC_ANALOG_TEST_CLOCK: r = ana_test;
			pin_readback_pkg::SRC_DIGITAL_CLOCKOUT: r = digital;
			default: r = daisy;
		endcase
		return r;
	endfunction

	// Readback only shows pins whose direction is forced and whose mode is input
	function automatic pin_readback_pkg::word_t gate_levels(
		input logic force_en,
		input pin_readback_pkg::word_t mode,
		input pin_readback_pkg::word_t levels
	);
		pin_readback_pkg::word_t r;
		r = force_en ? (mode & levels) : 16'h0000;
		return r;
	endfunction

	// Byte-lane merge for writable 16-bit words
	function automatic pin_readback_pkg::word_t merge_lanes(
		input pin_readback_pkg::word_t old_val,
		input logic [31:0] wdata,
		input logic [3:0] lanes
	);
		pin_readback_pkg::word_t r;
		r = old_val;
		if (lanes[0]) begin
			r[7:0] = wdata[7:0];
		end
		if (lanes[1]) begin
			r[15:8] = wdata[15:8];
		end
		return r;
	endfunction

	// Bus handshake state
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d;

	// Software-written state
	logic force_q, force_d;
	pin_readback_pkg::word_t mode_lower_q, mode_lower_d;
	logic [1:0] mode_upper_q, mode_upper_d;
	logic [1:0] sel_rsvd_q, sel_rsvd_d;
	logic ana_line_q, ana_line_d;
	pin_readback_pkg::clk_src_e ind1_sel_q, ind1_sel_d;
	pin_readback_pkg::clk_src_e clkout_sel_q, clkout_sel_d;

	// Strap latches
	logic ind1_por_q, ind1_por_d;
	logic rxd3_por_q, rxd3_por_d;
	logic rxd3_rst_q, rxd3_rst_d;
	logic ind0_q, ind0_d;
	logic [2:0] rxd_q, rxd_d;
	logic rxclk_q, rxclk_d;
	logic [1:0] rxerr_q, rxerr_d;
	logic [1:0] rxvalid_q, rxvalid_d;

	// Pin drivers
	logic ind1_pin_q, ind1_pin_d;
	logic clkout_pin_q, clkout_pin_d;

	logic req;
	logic wr;
	logic [13:0] idx;
	pin_readback_pkg::word_t lower_view;
	pin_readback_pkg::word_t upper_view;
	pin_readback_pkg::word_t boot_view;
	pin_readback_pkg::word_t sel_view;
	pin_readback_pkg::word_t sel_new;
	logic ana_clock;

	assign req = cyc_i & stb_i & ~ack_q;
	assign wr = req & we_i;
	assign idx = 14'(adr_i[ADR_W-1:2]);

	always_comb begin
		lower_view = gate_levels(force_q, mode_lower_q, pins_lower_i);
		lower_view[`LOWER_ZERO_BIT] = 1'b0;
		upper_view = gate_levels(force_q, {14'h0000, mode_upper_q}, {14'h0000, pins_upper_i});
		boot_view = 16'h0000;
		boot_view[`BOOT_IND1_POR_BIT] = ind1_por_q;
		boot_view[`BOOT_RXD3_POR_BIT] = rxd3_por_q;
		boot_view[`BOOT_IND0_BIT] = ind0_q;
		boot_view[`BOOT_RXD3_RST_BIT] = rxd3_rst_q;
		boot_view[`BOOT_RXD2_BIT -: 3] = rxd_q;
		boot_view[`BOOT_RXCLK_BIT] = rxclk_q;
		boot_view[`BOOT_RXERR_LSB +: 2] = rxerr_q;
		boot_view[`BOOT_RXVALID_LSB +: 2] = rxvalid_q;
		sel_view = 16'h0000;
		sel_view[`SEL_RSVD_RW_LSB +: 2] = sel_rsvd_q;
		sel_view[`SEL_ANA_LINE_BIT] = ana_line_q;
		sel_view[`SEL_IND1_LSB +: 2] = ind1_sel_q;
		sel_view[`SEL_CLKOUT_LSB +: 2] = clkout_sel_q;
		sel_new = merge_lanes(sel_view, dat_i, sel_i);
	end

	// Wishbone answer: one-cycle ack, registered read data
	always_comb begin
		ack_d = req;
		dat_d = 32'h0000_0000;
		if (req && !we_i) begin
			case (idx)
				`IDX_READBACK_LOWER: dat_d = {16'h0000, lower_view};
				`IDX_READBACK_UPPER: dat_d = {16'h0000, upper_view};
				`IDX_BOOT_LATCHES: dat_d = {16'h0000, boot_view};
				`IDX_OUTPUT_SELECT: dat_d = {16'h0000, sel_view};
				`IDX_FORCE_CTRL: dat_d = {31'h0000_0000, force_q};
				`IDX_MODE_LOWER: dat_d = {16'h0000, mode_lower_q};
				`IDX_MODE_UPPER: dat_d = {30'h0000_0000, mode_upper_q};
				default: dat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	// Writable registers; read-only words ignore writes
	always_comb begin
		force_d = force_q;
		mode_lower_d = mode_lower_q;
		mode_upper_d = mode_upper_q;
		sel_rsvd_d = sel_rsvd_q;
		ana_line_d = ana_line_q;
		ind1_sel_d = ind1_sel_q;
		clkout_sel_d = clkout_sel_q;
		if (wr) begin
			case (idx)
				`IDX_FORCE_CTRL: begin
					if (sel_i[0]) begin
						force_d = dat_i[`FORCE_CTRL_BIT];
					end
				end
				`IDX_MODE_LOWER: begin
					mode_lower_d = merge_lanes(mode_lower_q, dat_i, sel_i);
				end
				`IDX_MODE_UPPER: begin
					if (sel_i[0]) begin
						mode_upper_d = dat_i[`UPPER_USED_BITS-1:0];
					end
				end
				`IDX_OUTPUT_SELECT: begin
					sel_rsvd_d = sel_new[`SEL_RSVD_RW_LSB +: 2];
					ana_line_d = sel_new[`SEL_ANA_LINE_BIT];
					ind1_sel_d = pin_readback_pkg::clk_src_e'(sel_new[`SEL_IND1_LSB +: 2]);
					clkout_sel_d = pin_readback_pkg::clk_src_e'(sel_new[`SEL_CLKOUT_LSB +: 2]);
				end
				default: begin
					force_d = force_q;
				end
			endcase
		end
	end

	// Select defaults follow the receive-data-3 strap as it stands during reset
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			force_q <= 1'b0;
			mode_lower_q <= 16'h0000;
			mode_upper_q <= 2'h0;
			sel_rsvd_q <= 2'h0;
			ana_line_q <= 1'b0;
			ind1_sel_q <= pin_readback_pkg::clk_src_e'(rxdata3_strap_i ? `SEL_IND1_STRAPPED
				: `SEL_IND1_DEFAULT);
			clkout_sel_q <= pin_readback_pkg::clk_src_e'(rxdata3_strap_i ? `SEL_CLKOUT_STRAPPED
				: `SEL_CLKOUT_DEFAULT);
		end else begin
			force_q <= force_d;
			mode_lower_q <= mode_lower_d;
			mode_upper_q <= mode_upper_d;
			sel_rsvd_q <= sel_rsvd_d;
			ana_line_q <= ana_line_d;
			ind1_sel_q <= ind1_sel_d;
			clkout_sel_q <= clkout_sel_d;
		end
	end

	// Strap capture: power-up-only latches ignore the ordinary reset
	always_comb begin
		ind1_por_d = ind1_por_q;
		rxd3_por_d = rxd3_por_q;
		rxd3_rst_d = rxd3_rst_q;
		ind0_d = ind0_q;
		rxd_d = rxd_q;
		rxclk_d = rxclk_q;
		rxerr_d = rxerr_q;
		rxvalid_d = rxvalid_q;
		if (por_i) begin
			ind1_por_d = indicator1_strap_i;
			rxd3_por_d = rxdata3_strap_i;
		end
		if (por_i || rst_i) begin
			rxd3_rst_d = rxdata3_strap_i;
			ind0_d = indicator0_strap_i;
			rxd_d = {rxdata2_strap_i, rxdata1_strap_i, rxdata0_strap_i};
			rxclk_d = rxclock_strap_i;
			rxerr_d = rxerror_strap_i;
			rxvalid_d = rxvalid_strap_i;
		end
	end

	always_ff @(posedge clk_i) begin
		ind1_por_q <= ind1_por_d;
		rxd3_por_q <= rxd3_por_d;
		rxd3_rst_q <= rxd3_rst_d;
		ind0_q <= ind0_d;
		rxd_q <= rxd_d;
		rxclk_q <= rxclk_d;
		rxerr_q <= rxerr_d;
		rxvalid_q <= rxvalid_d;
	end

	// Pins are retimed so they come from flops; sources faster than clk_i are not reproduced faithfully
	always_comb begin
		ana_clock = ana_line_q ? analog_test_clock_b_i : analog_test_clock_a_i;
		ind1_pin_d = pick_source(ind1_sel_q, daisy_clock_i, transmit_test_clock_i, ana_clock,
			digital_clockout_i);
		clkout_pin_d = pick_source(clkout_sel_q, daisy_clock_i, transmit_test_clock_i, ana_clock,
			digital_clockout_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			ind1_pin_q <= 1'b0;
			clkout_pin_q <= 1'b0;
		end else begin
			ind1_pin_q <= ind1_pin_d;
			clkout_pin_q <= clkout_pin_d;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;
	assign analog_test_line_select_o = ana_line_q;
	assign indicator1_o = ind1_pin_q;
	assign clockout_o = clkout_pin_q;

endmodule

`default_nettype wire

// ### pin_readback_map.svh
// Purpose: Register indices, field positions and reset values of the pin readback, strap and clock-out block.
// Assumes: Word index times four gives the Wishbone byte address.
// Notes: Definitions only.
`ifndef PIN_READBACK_MAP_SVH
`define PIN_READBACK_MAP_SVH

`define IDX_READBACK_LOWER 14'h0457
`define IDX_READBACK_UPPER 14'h0458
`define IDX_BOOT_LATCHES 14'h045d
`define IDX_OUTPUT_SELECT 14'h045f
`define IDX_FORCE_CTRL 14'h0470
`define IDX_MODE_LOWER 14'h0471
`define IDX_MODE_UPPER 14'h0472

`define LOWER_ZERO_BIT 12
`define UPPER_USED_BITS 2

`define BOOT_IND1_POR_BIT 13
`define BOOT_RXD3_POR_BIT 12
`define BOOT_IND0_BIT 9
`define BOOT_RXD3_RST_BIT 8
`define BOOT_RXD2_BIT 7
`define BOOT_RXD1_BIT 6
`define BOOT_RXD0_BIT 5
`define BOOT_RXCLK_BIT 4
`define BOOT_RXERR_LSB 2
`define BOOT_RXVALID_LSB 0

`define SEL_RSVD_RW_LSB 14
`define SEL_ANA_LINE_BIT 4
`define SEL_IND1_LSB 2
`define SEL_CLKOUT_LSB 0

`define SEL_IND1_STRAPPED 2'h0
`define SEL_IND1_DEFAULT 2'h3
`define SEL_CLKOUT_STRAPPED 2'h3
`define SEL_CLKOUT_DEFAULT 2'h0

`define FORCE_CTRL_BIT 0

`endif

// ### pin_readback_pkg.sv
// Purpose: Types shared by the pin readback, strap and clock-out block.
// Assumes: Nothing beyond the map header.
// Notes: Constants live in the map header.
`default_nettype none

package pin_readback_pkg;
	typedef logic [15:0] word_t;

	typedef enum logic [1:0] {
		SRC_DAISY_CLOCK = 2'b00,
		SRC_TRANSMIT_TEST_CLOCK = 2'b01,
		SRC_ANALOG_TEST_CLOCK = 2'b10,
		SRC_DIGITAL_CLOCKOUT = 2'b11
	} clk_src_e;
endpackage

`default_nettype wire

// ### pin_readback_sva.sv
// Purpose: Bus handshake and pin output checks for the readback block.
// Assumes: Watches only the top module's ports.
// Notes: Bound after the module.
`default_nettype none
`include "pin_readback_map.svh"

module pin_readback_sva #(
	parameter int ADR_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic daisy_clock_i,
	input wire logic transmit_test_clock_i,
	input wire logic analog_test_clock_a_i,
	input wire logic analog_test_clock_b_i,
	input wire logic digital_clockout_i,
	input wire logic analog_test_line_select_o,
	input wire logic indicator1_o,
	input wire logic clockout_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || por_i);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	// With every source at one level, any select must give that level
	sequence s_same;
		!rst_i && !por_i && daisy_clock_i == transmit_test_clock_i && transmit_test_clock_i == analog_test_clock_a_i
			&& analog_test_clock_a_i == analog_test_clock_b_i && analog_test_clock_b_i == digital_clockout_i;
	endsequence
	// Read requests taken at one edge; their data stands in the next cycle
	sequence s_rd_lower;
		cyc_i && stb_i && !ack_o && !we_i && adr_i[ADR_W-1:2] == `IDX_READBACK_LOWER;
	endsequence
	sequence s_rd_upper;
		cyc_i && stb_i && !ack_o && !we_i && adr_i[ADR_W-1:2] == `IDX_READBACK_UPPER;
	endsequence
	sequence s_rd_boot;
		cyc_i && stb_i && !ack_o && !we_i && adr_i[ADR_W-1:2] == `IDX_BOOT_LATCHES;
	endsequence
	a_ack_follows: assert property (s_req |=> ack_o) else $error("ack missing after request");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
	a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
	a_upper_zero: assert property (dat_o[31:16] == 16'h0) else $error("upper read half not zero");
	a_lower_bit12: assert property (s_rd_lower |=> !dat_o[`LOWER_ZERO_BIT])
		else $error("lower readback bit 12 not zero");
	a_upper_rsvd: assert property (s_rd_upper |=> dat_o[15:`UPPER_USED_BITS] == 14'h0)
		else $error("upper readback reserved bits not zero");
	a_boot_rsvd: assert property (s_rd_boot |=> dat_o[15:14] == 2'h0 && dat_o[11:10] == 2'h0)
		else $error("boot latch reserved bits not zero");
	a_reset_quiet: assert property (disable iff (1'b0) (rst_i || por_i) |=> !ack_o && dat_o == 32'h0
		&& !analog_test_line_select_o) else $error("outputs not quiet after reset");
	a_ind1_agree: assert property (s_same |=> indicator1_o == $past(daisy_clock_i))
		else $error("indicator output not from a source");
	a_clkout_agree: assert property (s_same |=> clockout_o == $past(daisy_clock_i))
		else $error("clock-out output not from a source");
endmodule

bind pin_readback_strap_clkout_mux pin_readback_sva #(.ADR_W(ADR_W)) pin_readback_sva_inst (.clk_i(clk_i),
	.rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.dat_o(dat_o), .ack_o(ack_o), .daisy_clock_i(daisy_clock_i),
	.transmit_test_clock_i(transmit_test_clock_i), .analog_test_clock_a_i(analog_test_clock_a_i),
	.analog_test_clock_b_i(analog_test_clock_b_i), .digital_clockout_i(digital_clockout_i),
	.analog_test_line_select_o(analog_test_line_select_o), .indicator1_o(indicator1_o), .clockout_o(clockout_o));

`default_nettype wire

// ### tb_pin_readback_strap_clkout_mux.sv
// Purpose: Register and pin tests of the readback, strap and clock-out block.
// Assumes: Straps held steady around each reset.
// Notes: Strap vector order is ind1, ind0, rxd3..rxd0, rxclk, rxerr, rxvalid.
`default_nettype none
`include "pin_readback_map.svh"

module tb_pin_readback_strap_clkout_mux;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b0;
	logic por_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [15:0] adr = 16'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [15:0] pl = 16'h0;
	logic [1:0] pu = 2'h0;
	logic [10:0] st = 11'h659;
	logic [4:0] src = 5'h0;
	logic [31:0] dat_o;
	logic ack_o, ana_sel, ind1, clko, line;
	logic [1:0] code;
	logic [15:0] rd;
	int err_total = 0;
	int samples_checked = 0;
	int hot [5] = '{0, 1, 2, 4, 3};
	always #50 clk_i = ~clk_i;
	pin_readback_strap_clkout_mux pin_readback_strap_clkout_mux_inst (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.pins_lower_i(pl), .pins_upper_i(pu), .indicator1_strap_i(st[10]), .indicator0_strap_i(st[9]),
		.rxdata3_strap_i(st[8]), .rxdata2_strap_i(st[7]), .rxdata1_strap_i(st[6]), .rxdata0_strap_i(st[5]),
		.rxclock_strap_i(st[4]), .rxerror_strap_i(st[3:2]), .rxvalid_strap_i(st[1:0]), .daisy_clock_i(src[0]),
		.transmit_test_clock_i(src[1]), .analog_test_clock_a_i(src[2]), .analog_test_clock_b_i(src[3]),
		.digital_clockout_i(src[4]), .analog_test_line_select_o(ana_sel), .indicator1_o(ind1), .clockout_o(clko));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Waits for ack with no cycle limit of its own; the watchdog ends a hung wait
	task automatic wb(input logic w, input logic [13:0] idx, input logic [15:0] wd, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= s;
		dat <= {16'h0, wd};
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wrap_up();
		$display("compares %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#2000000;
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		por_i <= 1'b0;
		wb(1'b0, `IDX_BOOT_LATCHES, 16'h0, 4'h0);
		chk(rd, 16'h2259);
		wb(1'b0, `IDX_OUTPUT_SELECT, 16'h0, 4'h0);
		chk(rd, 16'h000c);
		$display("test power-up straps done");
		// Power-up-only bits must keep their first values across a plain reset
		st <= 11'h1a6;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `IDX_BOOT_LATCHES, 16'h0, 4'h0);
		chk(rd, 16'h21a6);
		wb(1'b0, `IDX_OUTPUT_SELECT, 16'h0, 4'h0);
		chk(rd, 16'h0003);
		$display("test reset straps done");
		pl <= 16'h5a5a;
		pu <= 2'b10;
		wb(1'b1, `IDX_FORCE_CTRL, 16'h1, 4'h3);
		wb(1'b0, `IDX_FORCE_CTRL, 16'h0, 4'h0);
		chk(rd, 16'h0001);
		wb(1'b1, `IDX_MODE_LOWER, 16'hffff, 4'h3);
		wb(1'b1, `IDX_MODE_UPPER, 16'h3, 4'h3);
		wb(1'b0, `IDX_MODE_UPPER, 16'h0, 4'h0);
		chk(rd, 16'h0003);
		wb(1'b0, `IDX_READBACK_LOWER, 16'h0, 4'h0);
		chk(rd, 16'h4a5a);
		wb(1'b0, `IDX_READBACK_UPPER, 16'h0, 4'h0);
		chk(rd, 16'h0002);
		wb(1'b1, `IDX_MODE_LOWER, 16'h00ff, 4'h3);
		wb(1'b0, `IDX_MODE_LOWER, 16'h0, 4'h0);
		chk(rd, 16'h00ff);
		wb(1'b0, `IDX_READBACK_LOWER, 16'h0, 4'h0);
		chk(rd, 16'h005a);
		wb(1'b1, `IDX_FORCE_CTRL, 16'h0, 4'h3);
		wb(1'b0, `IDX_READBACK_LOWER, 16'h0, 4'h0);
		chk(rd, 16'h0000);
		wb(1'b0, `IDX_READBACK_UPPER, 16'h0, 4'h0);
		chk(rd, 16'h0000);
		$display("test readback done");
		wb(1'b1, `IDX_OUTPUT_SELECT, 16'hffff, 4'h3);
		wb(1'b0, `IDX_OUTPUT_SELECT, 16'h0, 4'h0);
		chk(rd, 16'hc01f);
		chk(ana_sel, 1'b1);
		wb(1'b1, `IDX_OUTPUT_SELECT, 16'h0, 4'h2);
		wb(1'b0, `IDX_OUTPUT_SELECT, 16'h0, 4'h0);
		chk(rd, 16'h001f);
		wb(1'b1, `IDX_BOOT_LATCHES, 16'hffff, 4'h3);
		wb(1'b0, `IDX_BOOT_LATCHES, 16'h0, 4'h0);
		chk(rd, 16'h21a6);
		wb(1'b0, 14'h0400, 16'h0, 4'h0);
		chk(rd, 16'h0000);
		$display("test reserved bits done");
		// The last pass picks the analog source again on the second test line
		for (int k = 0; k < 5; k++) begin
			code = (k == 4) ? 2'h2 : 2'(k);
			line = (k == 4);
			wb(1'b1, `IDX_OUTPUT_SELECT, {11'h0, line, code, code}, 4'h3);
			chk(ana_sel, line);
			src <= 5'(1 << hot[k]);
			repeat (2) @(posedge clk_i);
			chk({ind1, clko}, 2'b11);
			src <= ~5'(1 << hot[k]);
			repeat (2) @(posedge clk_i);
			chk({ind1, clko}, 2'b00);
		end
		// Distinct codes on the two pins catch swapped select fields
		wb(1'b1, `IDX_OUTPUT_SELECT, 16'h000c, 4'h3);
		src <= 5'h10;
		repeat (2) @(posedge clk_i);
		chk({ind1, clko}, 2'b10);
		src <= 5'h01;
		repeat (2) @(posedge clk_i);
		chk({ind1, clko}, 2'b01);
		$display("test source select done");
		wrap_up();
	end
endmodule

`default_nettype wire
